//--- hw/channel_mode_bitbang_engine.sv
/*
 * Per-channel mode selection and pin engine for four bridge channels:
 * serial port pass-through, asynchronous and synchronous bit-bang, and a
 * byte-wide serial shifter on the first two channels. Assumes APB with
 * 32-bit data, host byte streams that hold valid until taken, and pin
 * inputs synchronous to clk_in.
 */
// Contract
// - Serial engine only on first two channels
// - Engine driven by bytes from host stream
// - Engine throughput limited by the divided clock
// - Serial clock rate selected by internal divider
// - Request 2 enters engine, 0 resets mode
// - Adaptive: wait for return clock before data
// - Adaptive clocking off after reset
// - Every channel supports both bit-bang variants
// - Host bytes drive only pins set output
// - Async outputs change on byte plus tick
// - Async pins hold last written value
// - Sync pins update and sample per byte
// - Sync output stalls while return slot full
// - Sync samples before drive, one byte lag
// - Request 1 enters asynchronous bit-bang
// - Request 4 enters synchronous bit-bang
// - Sample, send, drive, setup, then write strobe
// - Strobe indications stay internal only
// - Reset leaves all channels as serial ports
// - Mode ignores config memory except RS485 enable
// - Each channel keeps its own mode
`default_nettype none

module channel_mode_bitbang_engine
	import channel_mode_pkg::*;
(
	// Clock and reset
	input  wire logic                           clk_in,
	input  wire logic                           rst_b_in,
	// APB slave
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [7:0]                     paddr,
	input  wire logic [31:0]                    pwdata,
	output logic                                pready,
	output logic [31:0]                         prdata,
	output logic                                pslverr,
	// Host receive streams, one byte each
	input  wire logic [NUM_CH-1:0]              rx_valid_in,
	input  wire logic [NUM_CH-1:0][PIN_W-1:0]   rx_data_in,
	output logic [NUM_CH-1:0]                   rx_ready_out,
	// Host transmit streams, one byte each
	output logic [NUM_CH-1:0]                   tx_valid_out,
	output logic [NUM_CH-1:0][PIN_W-1:0]        tx_data_out,
	input  wire logic [NUM_CH-1:0]              tx_ready_in,
	// Parallel pins toward the target
	input  wire logic [NUM_CH-1:0][PIN_W-1:0]   pin_in,
	output logic [NUM_CH-1:0][PIN_W-1:0]        pin_out,
	output logic [NUM_CH-1:0][PIN_W-1:0]        pin_oe_out,
	// Serial port side
	input  wire logic                           rs485_option_in,
	input  wire logic [NUM_CH-1:0]              uart_tx_busy_in,
	output logic [NUM_CH-1:0]                   rs485_transmit_enable_out
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic req_legal(input logic [7:0] val, input logic [1:0] ch);
		req_legal = (val == REQ_RESET) || (val == REQ_ASYNC_BB) || (val == REQ_SYNC_BB) ||
			((val == REQ_ENGINE) && (int'(ch) < ENGINE_CHANNELS));
	endfunction : req_legal

	function automatic chan_mode_e req_mode(input logic [7:0] val);
		unique case (val)
			REQ_ASYNC_BB: req_mode = MODE_ASYNC_BITBANG;
			REQ_SYNC_BB:  req_mode = MODE_SYNC_BITBANG;
			REQ_ENGINE:   req_mode = MODE_SERIAL_ENGINE;
			default:      req_mode = MODE_SERIAL_PORT;
		endcase
	endfunction : req_mode

	function automatic chan_s chan_enter(input chan_mode_e mode);
		chan_s c;
		c = '0;
		c.mode = mode;
		chan_enter = c;
	endfunction : chan_enter

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	engine_state_s s_reg;
	engine_state_s s_next;

	logic        access;
	logic        wr_done;
	logic        mode_wr;
	logic [1:0]  mode_wr_ch;
	logic [7:0]  mode_wr_val;

	assign access      = psel && penable;
	// Writes land on the edge at which the master sees pready high.
	assign wr_done     = access && pwrite && s_reg.pready;
	assign mode_wr     = wr_done && (paddr == ADDR_MODE_REQ);
	assign mode_wr_ch  = pwdata[MODE_CH_LSB +: 2];
	assign mode_wr_val = pwdata[MODE_VAL_LSB +: 8];

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic take;
		logic [7:0] dir_i;
		take  = 1'b0;
		dir_i = 8'h00;
		s_next = s_reg;
		s_next.pready  = 1'b0;
		s_next.pslverr = 1'b0;

		// Shared pacing tick for asynchronous bit-bang.
		if (s_reg.baud_cnt >= s_reg.baud_div) begin
			s_next.baud_cnt  = 16'h0000;
			s_next.baud_tick = 1'b1;
		end else begin
			s_next.baud_cnt  = s_reg.baud_cnt + 16'h0001;
			s_next.baud_tick = 1'b0;
		end

		for (int i = 0; i < NUM_CH; i++) begin
			take  = rx_valid_in[i] && s_reg.ch[i].rx_ready;
			dir_i = s_reg.dir[i*PIN_W +: PIN_W];
			s_next.ch[i].rx_ready                = 1'b0;
			s_next.ch[i].write_strobe_indication = 1'b0;
			s_next.ch[i].read_strobe_indication  = 1'b0;
			// Clear before any set below so a fresh byte is never lost.
			if (s_reg.ch[i].tx_valid && tx_ready_in[i]) begin
				s_next.ch[i].tx_valid = 1'b0;
			end
			s_next.ch[i].rs485_transmit_enable = rs485_option_in && uart_tx_busy_in[i] &&
				(s_reg.ch[i].mode == MODE_SERIAL_PORT);

			unique case (s_reg.ch[i].mode)
				MODE_SERIAL_PORT: begin
					s_next.ch[i].pin_oe = 8'h00;
				end
				MODE_ASYNC_BITBANG: begin
					s_next.ch[i].pin_oe = dir_i;
					if (take) begin
						s_next.ch[i].hold_data = rx_data_in[i];
						s_next.ch[i].hold_full = 1'b1;
					end else if (!s_reg.ch[i].hold_full && rx_valid_in[i] &&
						!s_reg.ch[i].rx_ready) begin
						s_next.ch[i].rx_ready = 1'b1;
					end
					if (s_reg.baud_tick && s_reg.ch[i].hold_full) begin
						s_next.ch[i].pin_out   = s_reg.ch[i].hold_data & dir_i;
						s_next.ch[i].hold_full = 1'b0;
					end
					// Otherwise pin_out keeps its last value.
				end
				MODE_SYNC_BITBANG: begin
					s_next.ch[i].pin_oe = dir_i;
					unique case (s_reg.ch[i].bb_phase)
						BB_IDLE: begin
							if (take) begin
								s_next.ch[i].hold_data = rx_data_in[i];
								s_next.ch[i].bb_phase  = BB_SAMPLE;
							end else if (rx_valid_in[i] && !s_reg.ch[i].rx_ready &&
								!s_reg.ch[i].tx_valid) begin
								s_next.ch[i].rx_ready = 1'b1;
							end
						end
						BB_SAMPLE: begin
							// Old pin state goes back first.
							s_next.ch[i].tx_data  = pin_in[i];
							s_next.ch[i].tx_valid = 1'b1;
							s_next.ch[i].read_strobe_indication = 1'b1;
							s_next.ch[i].bb_phase = BB_DRIVE;
						end
						BB_DRIVE: begin
							s_next.ch[i].pin_out  = s_reg.ch[i].hold_data & dir_i;
							s_next.ch[i].bb_phase = BB_SETUP;
						end
						BB_SETUP: begin
							s_next.ch[i].bb_phase = BB_STROBE;
						end
						BB_STROBE: begin
							s_next.ch[i].write_strobe_indication = 1'b1;
							s_next.ch[i].bb_phase = BB_IDLE;
						end
						default: begin
							s_next.ch[i].bb_phase = BB_IDLE;
						end
					endcase
				end
				MODE_SERIAL_ENGINE: begin
					// Each host byte shifts out MSB first; the byte seen on
					// the data input returns to the host.
					s_next.ch[i].pin_oe = ENGINE_OE;
					unique case (s_reg.ch[i].eng_phase)
						ENG_IDLE: begin
							if (take) begin
								s_next.ch[i].shift   = rx_data_in[i];
								s_next.ch[i].pin_out[PIN_DOUT] = rx_data_in[i][7];
								s_next.ch[i].bit_cnt = 3'h0;
								s_next.ch[i].div_cnt = 8'h00;
								s_next.ch[i].eng_phase = ENG_LOW;
							end else if (rx_valid_in[i] && !s_reg.ch[i].rx_ready &&
								!s_reg.ch[i].tx_valid) begin
								s_next.ch[i].rx_ready = 1'b1;
							end
						end
						ENG_LOW: begin
							if (s_reg.ch[i].div_cnt >= s_reg.eng_div[i]) begin
								s_next.ch[i].div_cnt = 8'h00;
								s_next.ch[i].pin_out[PIN_SCLK] = 1'b1;
								s_next.ch[i].capture = {s_reg.ch[i].capture[6:0],
									pin_in[i][PIN_DIN]};
								s_next.ch[i].eng_phase = s_reg.adaptive[i] ?
									ENG_WAIT_RCLK : ENG_HIGH;
							end else begin
								s_next.ch[i].div_cnt = s_reg.ch[i].div_cnt + 8'h01;
							end
						end
						ENG_WAIT_RCLK: begin
							if (pin_in[i][PIN_RCLK]) begin
								s_next.ch[i].eng_phase = ENG_HIGH;
							end
						end
						ENG_HIGH: begin
							if (s_reg.ch[i].div_cnt >= s_reg.eng_div[i]) begin
								s_next.ch[i].div_cnt = 8'h00;
								s_next.ch[i].pin_out[PIN_SCLK] = 1'b0;
								if (s_reg.ch[i].bit_cnt == LAST_BIT) begin
									s_next.ch[i].tx_data   = s_reg.ch[i].capture;
									s_next.ch[i].tx_valid  = 1'b1;
									s_next.ch[i].eng_phase = ENG_IDLE;
								end else begin
									s_next.ch[i].bit_cnt = s_reg.ch[i].bit_cnt + 3'h1;
									s_next.ch[i].shift   = {s_reg.ch[i].shift[6:0], 1'b0};
									s_next.ch[i].pin_out[PIN_DOUT] = s_reg.ch[i].shift[6];
									s_next.ch[i].eng_phase = ENG_LOW;
								end
							end else begin
								s_next.ch[i].div_cnt = s_reg.ch[i].div_cnt + 8'h01;
							end
						end
					endcase
				end
			endcase
		end

		// Register bus: one wait state, then pready for one cycle.
		if (access && !s_reg.pready) begin
			s_next.pready = 1'b1;
			s_next.prdata = 32'h0000_0000;
			unique case (paddr)
				ADDR_MODE_REQ: begin
					for (int i = 0; i < NUM_CH; i++) begin
						s_next.prdata[2*i +: 2] = s_reg.ch[i].mode;
					end
				end
				ADDR_DIRECTION:  s_next.prdata = s_reg.dir;
				ADDR_ENGINE_CFG: begin
					s_next.prdata[ENG_DIV1_LSB-8 +: 8] = s_reg.eng_div[0];
					s_next.prdata[ENG_DIV1_LSB +: 8]   = s_reg.eng_div[1];
					s_next.prdata[ADAPT_LSB +: 2]      = s_reg.adaptive[1:0];
				end
				ADDR_BAUD_DIV:   s_next.prdata[15:0] = s_reg.baud_div;
				ADDR_STATUS: begin
					for (int i = 0; i < NUM_CH; i++) begin
						s_next.prdata[i] = s_reg.ch[i].tx_valid;
						s_next.prdata[STAT_BUSY_LSB + i] = (s_reg.ch[i].bb_phase != BB_IDLE) ||
							(s_reg.ch[i].eng_phase != ENG_IDLE) || s_reg.ch[i].hold_full;
					end
				end
				default: s_next.pslverr = 1'b1;
			endcase
		end
		if (wr_done) begin
			unique case (paddr)
				ADDR_MODE_REQ: begin
					if (req_legal(mode_wr_val, mode_wr_ch)) begin
						// Only the addressed channel changes.
						s_next.ch[mode_wr_ch] = chan_enter(req_mode(mode_wr_val));
					end
				end
				ADDR_DIRECTION:  s_next.dir = pwdata;
				ADDR_ENGINE_CFG: begin
					s_next.eng_div[0]    = pwdata[ENG_DIV1_LSB-8 +: 8];
					s_next.eng_div[1]    = pwdata[ENG_DIV1_LSB +: 8];
					s_next.adaptive[1:0] = pwdata[ADAPT_LSB +: 2];
				end
				ADDR_BAUD_DIV:   s_next.baud_div = pwdata[15:0];
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_reg          <= '0;
			s_reg.baud_div <= BAUD_DIV_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	always_comb begin
		pready  = s_reg.pready;
		prdata  = s_reg.prdata;
		pslverr = s_reg.pslverr;
		for (int i = 0; i < NUM_CH; i++) begin
			rx_ready_out[i]              = s_reg.ch[i].rx_ready;
			tx_valid_out[i]              = s_reg.ch[i].tx_valid;
			tx_data_out[i]               = s_reg.ch[i].tx_data;
			pin_out[i]                   = s_reg.ch[i].pin_out;
			pin_oe_out[i]                = s_reg.ch[i].pin_oe;
			rs485_transmit_enable_out[i] = s_reg.ch[i].rs485_transmit_enable;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);

	a_engine_low_only: assert property (
		(s_reg.ch[2].mode != MODE_SERIAL_ENGINE) && (s_reg.ch[3].mode != MODE_SERIAL_ENGINE))
		else $error("serial engine on an upper channel");

	a_req_sets_mode: assert property (
		mode_wr && req_legal(mode_wr_val, mode_wr_ch) && (mode_wr_ch == 2'h0) |=>
		s_reg.ch[0].mode == req_mode($past(mode_wr_val)))
		else $error("mode request did not take effect");

	a_adaptive_hold: assert property (
		(s_reg.ch[0].eng_phase == ENG_WAIT_RCLK) && !pin_in[0][PIN_RCLK] && !mode_wr |=>
		$stable(pin_out[0][PIN_DOUT]) && (s_reg.ch[0].eng_phase == ENG_WAIT_RCLK))
		else $error("data changed before return clock");

	a_adaptive_cfg_only: assert property (
		!(wr_done && (paddr == ADDR_ENGINE_CFG)) |=> $stable(s_reg.adaptive))
		else $error("adaptive enable changed without a write");

	a_async_pace: assert property (
		(s_reg.ch[3].mode == MODE_ASYNC_BITBANG) && !s_reg.baud_tick && !mode_wr |=>
		$stable(pin_out[3]))
		else $error("async pins moved without a tick");

	a_sync_order: assert property (
		(s_reg.ch[2].bb_phase == BB_SAMPLE) && !mode_wr ##1 !mode_wr [*3] |->
		($past(s_reg.ch[2].bb_phase, 2) == BB_DRIVE) && $past(tx_valid_out[2], 2) &&
		($past(s_reg.ch[2].bb_phase) == BB_SETUP) &&
		(s_reg.ch[2].bb_phase == BB_STROBE) && $stable(pin_out[2]) ##1
		s_reg.ch[2].write_strobe_indication)
		else $error("sync cycle out of order");

	a_sync_stall: assert property (
		(s_reg.ch[2].mode == MODE_SYNC_BITBANG) && tx_valid_out[2] && !tx_ready_in[2] |=>
		!rx_ready_out[2])
		else $error("sync byte accepted while return slot full");

	a_bitbang_oe: assert property (
		(s_reg.ch[2].mode inside {MODE_ASYNC_BITBANG, MODE_SYNC_BITBANG}) && !mode_wr |=>
		pin_oe_out[2] == $past(s_reg.dir[2*PIN_W +: PIN_W]))
		else $error("bit-bang pin enables differ from direction");

	a_illegal_keeps: assert property (
		mode_wr && !req_legal(mode_wr_val, mode_wr_ch) |=>
		$stable({s_reg.ch[0].mode, s_reg.ch[1].mode, s_reg.ch[2].mode, s_reg.ch[3].mode}))
		else $error("unsupported request changed a mode");

	a_rs485_serial: assert property (
		rs485_transmit_enable_out[1] |-> $past(s_reg.ch[1].mode) == MODE_SERIAL_PORT)
		else $error("transmit enable outside serial port mode");

	a_channel_indep: assert property (
		mode_wr && (mode_wr_ch == 2'h0) |=> $stable(s_reg.ch[1].mode))
		else $error("mode write disturbed another channel");

	c_sync_cycle:  cover property (s_reg.ch[2].write_strobe_indication);
	c_engine_byte: cover property ((s_reg.ch[0].mode == MODE_SERIAL_ENGINE) && tx_valid_out[0]);
	c_async_drive: cover property ((s_reg.ch[3].mode == MODE_ASYNC_BITBANG) && s_reg.baud_tick &&
		s_reg.ch[3].hold_full);
	c_rclk_wait:   cover property ((s_reg.ch[0].eng_phase == ENG_WAIT_RCLK) ##1
		(s_reg.ch[0].eng_phase == ENG_HIGH));

endmodule : channel_mode_bitbang_engine

`default_nettype wire

//--- hw/channel_mode_pkg.sv
/*
 * Constants, enumerations and state layouts for the per-channel mode
 * and pin-level engine. Assumes a single 25 MHz clock domain.
 */
`default_nettype none

package channel_mode_pkg;

	// ------------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------------
	localparam int NUM_CH          = 4;
	localparam int PIN_W           = 8;
	localparam int ENGINE_CHANNELS = 2;

	// ------------------------------------------------------------------
	// Register offsets and fields
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_MODE_REQ   = 8'h00;
	localparam logic [7:0] ADDR_DIRECTION  = 8'h04;
	localparam logic [7:0] ADDR_ENGINE_CFG = 8'h08;
	localparam logic [7:0] ADDR_BAUD_DIV   = 8'h0C;
	localparam logic [7:0] ADDR_STATUS     = 8'h10;
	localparam int         MODE_VAL_LSB    = 0;
	localparam int         MODE_CH_LSB     = 8;
	localparam int         ENG_DIV1_LSB    = 8;
	localparam int         ADAPT_LSB       = 16;
	localparam int         STAT_BUSY_LSB   = 4;

	// ------------------------------------------------------------------
	// Mode request codes and reset values
	// ------------------------------------------------------------------
	localparam logic [7:0]  REQ_RESET      = 8'h00;
	localparam logic [7:0]  REQ_ASYNC_BB   = 8'h01;
	localparam logic [7:0]  REQ_ENGINE     = 8'h02;
	localparam logic [7:0]  REQ_SYNC_BB    = 8'h04;
	localparam logic [15:0] BAUD_DIV_RESET = 16'h0018;

	// ------------------------------------------------------------------
	// Serial engine pin assignment within a channel
	// ------------------------------------------------------------------
	localparam int         PIN_SCLK   = 0;
	localparam int         PIN_DOUT   = 1;
	localparam int         PIN_DIN    = 2;
	localparam int         PIN_RCLK   = 3;
	localparam logic [7:0] ENGINE_OE  = 8'h03;
	localparam logic [2:0] LAST_BIT   = 3'h7;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_SERIAL_PORT,
		MODE_ASYNC_BITBANG,
		MODE_SYNC_BITBANG,
		MODE_SERIAL_ENGINE
	} chan_mode_e;

	typedef enum logic [2:0] {BB_IDLE, BB_SAMPLE, BB_DRIVE, BB_SETUP, BB_STROBE} bb_phase_e;

	typedef enum logic [1:0] {ENG_IDLE, ENG_LOW, ENG_HIGH, ENG_WAIT_RCLK} eng_phase_e;

	typedef struct packed {
		chan_mode_e  mode;
		bb_phase_e   bb_phase;
		eng_phase_e  eng_phase;
		logic [7:0]  hold_data;
		logic        hold_full;
		logic        rx_ready;
		logic        tx_valid;
		logic [7:0]  tx_data;
		logic [7:0]  pin_out;
		logic [7:0]  pin_oe;
		logic [7:0]  shift;
		logic [7:0]  capture;
		logic [2:0]  bit_cnt;
		logic [7:0]  div_cnt;
		logic        write_strobe_indication;
		logic        read_strobe_indication;
		logic        rs485_transmit_enable;
	} chan_s;

	typedef struct packed {
		chan_s [NUM_CH-1:0]      ch;
		logic [31:0]             dir;
		logic [NUM_CH-1:0][7:0]  eng_div;
		logic [NUM_CH-1:0]       adaptive;
		logic [15:0]             baud_div;
		logic [15:0]             baud_cnt;
		logic                    baud_tick;
		logic                    pready;
		logic                    pslverr;
		logic [31:0]             prdata;
	} engine_state_s;

endpackage : channel_mode_pkg

`default_nettype wire

//--- testbench/target_device_model.sv
/*
 * Target device on the parallel pins: pull-ups on released pins, data
 * loop-back and a delayed return clock on the serial engine channels.
 * Assumes the engine's pin_out and pin_oe_out as its inputs.
 */
`default_nettype none

module target_device_model
	import channel_mode_pkg::*;
#(
	parameter int RET_DELAY = 2
)(
	// Clock
	input  wire logic                         clk_in,
	// Pins as driven by the device
	input  wire logic [NUM_CH-1:0][PIN_W-1:0] drive_in,
	input  wire logic [NUM_CH-1:0][PIN_W-1:0] drive_en_in,
	// Pin levels seen by the device
	output logic      [NUM_CH-1:0][PIN_W-1:0] level_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [ENGINE_CHANNELS-1:0][3:0] ret_pipe;

	// A slow target answers the serial clock late, so the wait is exercised.
	always_ff @(posedge clk_in) begin
		for (int c = 0; c < ENGINE_CHANNELS; c++) begin
			ret_pipe[c] <= {ret_pipe[c][2:0], drive_in[c][PIN_SCLK]};
		end
	end

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			level_out[c] = (drive_in[c] & drive_en_in[c]) | ~drive_en_in[c];
		end
		for (int c = 0; c < ENGINE_CHANNELS; c++) begin
			if (!drive_en_in[c][PIN_DIN])
				level_out[c][PIN_DIN] = level_out[c][PIN_DOUT];
			if (!drive_en_in[c][PIN_RCLK])
				level_out[c][PIN_RCLK] = ret_pipe[c][RET_DELAY-1];
		end
	end

endmodule : target_device_model

`default_nettype wire

//--- testbench/test_channel_mode_bitbang_engine.sv
/*
 * Self-checking bench for the channel mode and pin engine.
 * Assumes the APB timing and stream handshakes of the engine's ports.
 */
`default_nettype none

module test_channel_mode_bitbang_engine
	import channel_mode_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	logic                         clk_in, rst_b_in, psel, penable, pwrite, pready, pslverr;
	logic                         rs485_option_in;
	logic [7:0]                   paddr;
	logic [31:0]                  pwdata, prdata;
	logic [NUM_CH-1:0]            rx_valid_in, rx_ready_out, tx_valid_out, tx_ready_in;
	logic [NUM_CH-1:0]            uart_tx_busy_in, rs485_transmit_enable_out;
	logic [NUM_CH-1:0][PIN_W-1:0] rx_data_in, tx_data_out, pin_in, pin_out, pin_oe_out;
	int                           n_mismatch, checks_done;

	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d, exp; logic err;} row_s;
	row_s rows [14] = '{
		'{1'b0, ADDR_MODE_REQ, 32'h0, 32'h0, 1'b0},
		'{1'b0, ADDR_ENGINE_CFG, 32'h0, 32'h0, 1'b0},
		'{1'b0, ADDR_BAUD_DIV, 32'h0, 32'h18, 1'b0},
		'{1'b1, 8'h14, 32'h5, 32'h0, 1'b1},
		'{1'b1, ADDR_DIRECTION, 32'hFF0F_0000, 32'hFF0F_0000, 1'b0},
		'{1'b1, ADDR_ENGINE_CFG, 32'h0001_0001, 32'h0001_0001, 1'b0},
		'{1'b1, ADDR_BAUD_DIV, 32'h3, 32'h3, 1'b0},
		'{1'b1, ADDR_MODE_REQ, 32'h002, 32'h03, 1'b0},
		'{1'b1, ADDR_MODE_REQ, 32'h202, 32'h03, 1'b0},
		'{1'b1, ADDR_MODE_REQ, 32'h104, 32'h0B, 1'b0},
		'{1'b1, ADDR_MODE_REQ, 32'h301, 32'h4B, 1'b0},
		'{1'b1, ADDR_MODE_REQ, 32'h107, 32'h4B, 1'b0},
		'{1'b1, ADDR_MODE_REQ, 32'h100, 32'h43, 1'b0},
		'{1'b1, ADDR_MODE_REQ, 32'h204, 32'h63, 1'b0}};
	logic [7:0] sync_tx [3] = '{8'h55, 8'hAA, 8'hAA};
	logic [7:0] sync_rx [3] = '{8'hF0, 8'hF5, 8'hFA};

	channel_mode_bitbang_engine i_channel_mode_bitbang_engine (.clk_in(clk_in),
		.rst_b_in(rst_b_in), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in), .rx_ready_out(rx_ready_out),
		.tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
		.rs485_option_in(rs485_option_in), .uart_tx_busy_in(uart_tx_busy_in),
		.rs485_transmit_enable_out(rs485_transmit_enable_out));
	target_device_model i_target_device_model (.clk_in(clk_in), .drive_in(pin_out),
		.drive_en_in(pin_oe_out), .level_out(pin_in));

	always #20 clk_in = ~clk_in;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, seen);
			n_mismatch++;
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge clk_in);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) n_mismatch++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic raise(input int c, input logic [7:0] b);
		@(posedge clk_in);
		rx_valid_in[c] <= 1'b1;
		rx_data_in[c] <= b;
	endtask : raise

	task automatic take(input int c);
		int n;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (rx_ready_out[c] !== 1'b1 && n < 200);
		if (rx_ready_out[c] !== 1'b1) n_mismatch++;
		rx_valid_in[c] <= 1'b0;
	endtask : take

	task automatic recv(input int c, output logic [7:0] b);
		int n;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (tx_valid_out[c] !== 1'b1 && n < 500);
		if (tx_valid_out[c] !== 1'b1) n_mismatch++;
		b = tx_data_out[c];
	endtask : recv

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	initial begin : watchdog
		repeat (20000) @(posedge clk_in);
		n_mismatch++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin : main_seq
		logic [31:0] r;
		logic        e;
		logic [7:0]  b;
		logic        s;
		{clk_in, rst_b_in, psel, penable, pwrite, paddr, pwdata} = '0;
		{rx_valid_in, rx_data_in, uart_tx_busy_in, rs485_option_in} = '0;
		tx_ready_in = '1;
		n_mismatch = 0;
		checks_done = 0;
		repeat (3) @(posedge clk_in);
		rst_b_in <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w)
				apb(1'b1, rows[i].a, rows[i].d, r, e);
			apb(1'b0, rows[i].a, 32'h0, r, e);
			check("register", r, rows[i].exp);
			check("slave error", 32'(e), 32'(rows[i].err));
		end
		apb(1'b1, ADDR_MODE_REQ, 32'h204, r, e);
		apb(1'b1, ADDR_MODE_REQ, 32'h301, r, e);
		apb(1'b1, ADDR_MODE_REQ, 32'h002, r, e);
		rs485_option_in <= 1'b1;
		uart_tx_busy_in <= 4'h3;
		repeat (3) @(posedge clk_in);
		check("rs485 enable", 32'(rs485_transmit_enable_out), 32'h2);
		check("sync oe", 32'(pin_oe_out[2]), 32'h0F);
		foreach (sync_tx[i]) begin
			raise(2, sync_tx[i]);
			take(2);
			recv(2, b);
			check("sync sample", 32'(b), 32'(sync_rx[i]));
		end
		repeat (3) @(posedge clk_in);
		check("sync pins", 32'(pin_out[2]), 32'h0A);
		// With the return slot full a second byte must wait in the host stream.
		tx_ready_in[2] <= 1'b0;
		raise(2, 8'h01);
		take(2);
		raise(2, 8'h02);
		s = 1'b0;
		repeat (20) begin
			@(posedge clk_in);
			s = s | (rx_ready_out[2] === 1'b1);
		end
		check("stall", 32'(s), 32'h0);
		apb(1'b0, ADDR_STATUS, 32'h0, r, e);
		check("status", r, 32'h4);
		tx_ready_in[2] <= 1'b1;
		recv(2, b);
		check("stall sample", 32'(b), 32'hFA);
		take(2);
		recv(2, b);
		check("resume sample", 32'(b), 32'hF1);
		raise(3, 8'h3C);
		take(3);
		repeat (8) @(posedge clk_in);
		check("async pins", 32'(pin_out[3]), 32'h3C);
		repeat (40) @(posedge clk_in);
		check("async hold", 32'(pin_out[3]), 32'h3C);
		check("engine oe", 32'(pin_oe_out[0]), 32'(ENGINE_OE));
		raise(0, 8'hA5);
		take(0);
		recv(0, b);
		check("engine loop", 32'(b), 32'hA5);
		@(posedge clk_in);
		rst_b_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		apb(1'b0, ADDR_MODE_REQ, 32'h0, r, e);
		check("mode after reset", r, 32'h0);
		check("oe after reset", 32'(pin_oe_out), 32'h0);
		apb(1'b0, ADDR_ENGINE_CFG, 32'h0, r, e);
		check("engine cfg after reset", r, 32'h0);
		print_verdict();
	end

endmodule : test_channel_mode_bitbang_engine

`default_nettype wire
